/* File: rtl/lcd_ctrl_regs.svh */
`ifndef LCD_CTRL_REGS_SVH
`define LCD_CTRL_REGS_SVH

// =====================================
// Register offsets
`define LCD_OFS_CMD 4'h0
`define LCD_OFS_DATA 4'h1
`define LCD_OFS_STATUS 4'h2
`define LCD_OFS_POWER 4'h3
`define LCD_OFS_CONTRAST 4'h4
`define LCD_OFS_PAGE 4'h5
`define LCD_OFS_COLUMN 4'h6
`define LCD_OFS_START 4'h7
`define LCD_OFS_STATIC 4'h8

// =====================================
// Command byte patterns
`define LCD_CMD_DISPLAY 8'b1010_111?
`define LCD_CMD_START_LINE 8'b01??_????
`define LCD_CMD_PAGE 8'b1011_????
`define LCD_CMD_COL_HIGH 8'b0001_????
`define LCD_CMD_COL_LOW 8'b0000_????
`define LCD_CMD_SEG_DIR 8'b1010_000?
`define LCD_CMD_INVERSE 8'b1010_011?
`define LCD_CMD_ALL_ON 8'b1010_010?
`define LCD_CMD_BIAS 8'b1010_001?
`define LCD_CMD_POWER 8'b0010_1???
`define LCD_CMD_COM_DIR 8'b1100_????
`define LCD_CMD_STATIC 8'b1010_110?
`define LCD_CMD_CONTRAST 8'h81
`define LCD_CMD_RATIO 8'h82
`define LCD_CMD_RMW_ENTER 8'he0
`define LCD_CMD_RMW_EXIT 8'hee
`define LCD_CMD_SOFT_RESET 8'he2

// =====================================
// Field positions and limits
`define LCD_COM_DIR_BIT 3
`define LCD_PWR_BOOST_BIT 2
`define LCD_PWR_REG_BIT 1
`define LCD_PWR_FOLLOW_BIT 0
`define LCD_PAGE_MAX 4'h8
`define LCD_COL_MAX 8'h83
`define LCD_SER_LAST_BIT 3'h7

// =====================================
// Reset values
`define LCD_CONTRAST_RST 6'h20
`define LCD_POWER_RST 3'h0
`define LCD_STATIC_RST 2'h0
`define LCD_RATIO_RST 3'h0

// =====================================
// Duty codes and bias denominators
`define LCD_DUTY_65 3'h0
`define LCD_DUTY_49 3'h1
`define LCD_DUTY_53 3'h2
`define LCD_DUTY_55 3'h3
`define LCD_DUTY_33 3'h4
`define LCD_BIAS_9 4'h9
`define LCD_BIAS_8 4'h8
`define LCD_BIAS_7 4'h7
`define LCD_BIAS_6 4'h6
`define LCD_BIAS_5 4'h5

`endif

/* File: rtl/lcd_ctrl_pkg.sv */
package lcd_ctrl_pkg;

  typedef enum logic [1:0] {
    PEND_NONE,
    PEND_CONTRAST,
    PEND_RATIO,
    PEND_STATIC
  } pend_t;

  typedef struct packed {
    logic display_on;
    logic inverse;
    logic seg_reverse;
    logic [2:0] power_ctrl;
    logic bias_alt;
    logic all_on;
    logic power_saver;
    logic drivers_at_supply;
    logic rmw;
    logic [1:0] static_ind;
    logic [5:0] start_line;
    logic [7:0] column;
    logic [7:0] rmw_column;
    logic [3:0] page;
    logic com_reverse;
    logic [2:0] ratio;
    logic [5:0] contrast;
    pend_t pend;
  } cfg_t;

  typedef struct packed {
    logic booster;
    logic regulator;
    logic follower;
    logic divider_connect;
    logic reg_feedback;
    logic high_power;
    logic [3:0] bias_denom;
    logic [5:0] contrast_step;
  } drive_t;

  typedef struct packed {
    logic [7:0] data;
    logic is_data;
  } ser_byte_t;

endpackage

/* File: rtl/lcd_serial_rx.sv */
`timescale 1ns/1ps
`default_nettype none
`include "lcd_ctrl_regs.svh"

module lcd_serial_rx
  import lcd_ctrl_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_clk_en,
  input wire logic i_clear,
  input wire logic i_ser_cs_n,
  input wire logic i_ser_clk,
  input wire logic i_ser_data,
  input wire logic i_ser_a0,
  input wire logic i_ack,
  output ser_byte_t o_byte,
  output logic o_valid
);

  logic [7:0] shift, next_shift;
  logic [2:0] count, next_count;
  logic clk_prev, next_clk_prev;
  ser_byte_t held, next_held;
  logic valid, next_valid;

  // =====================================
  // Shift register, first bit is the MSB
  always_comb begin
    next_shift = shift;
    next_count = count;
    next_clk_prev = i_ser_clk;
    next_held = held;
    next_valid = valid && !i_ack;
    if (i_ser_cs_n) begin
      next_count = 3'h0;
    end else if (i_ser_clk && !clk_prev) begin
      next_shift = {shift[6:0], i_ser_data};
      next_count = count + 3'h1;
      if (count == `LCD_SER_LAST_BIT) begin
        next_held.data = {shift[6:0], i_ser_data};
        next_held.is_data = i_ser_a0;
        next_valid = 1'b1;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_clear) begin
      shift <= 8'h00;
      count <= 3'h0;
      // Follows the pin, no false edge on release
      clk_prev <= i_ser_clk;
      held <= '0;
      valid <= 1'b0;
    end else if (i_clk_en) begin
      shift <= next_shift;
      count <= next_count;
      clk_prev <= next_clk_prev;
      held <= next_held;
      valid <= next_valid;
    end
  end

  assign o_byte = held;
  assign o_valid = valid;

endmodule

`default_nettype wire

/* File: rtl/lcd_ctrl_reset_power_setup.sv */
`timescale 1ns/1ps
`default_nettype none
`include "lcd_ctrl_regs.svh"

module lcd_ctrl_reset_power_setup
  import lcd_ctrl_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic i_clk_en,
  input wire logic i_init_pin_n,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wr_data,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  output logic [7:0] o_rd_data,
  input wire logic i_ser_cs_n,
  input wire logic i_ser_clk,
  input wire logic i_ser_data,
  input wire logic i_ser_a0,
  input wire logic [2:0] i_duty_sel,
  input wire logic i_regulator_resistor_select,
  input wire logic i_drive_strength_select,
  input wire logic i_feedback_input,
  input wire logic i_internal_feedback,
  output logic o_display_on,
  output logic o_inverse,
  output logic o_seg_reverse,
  output logic o_com_reverse,
  output logic o_all_on,
  output logic o_power_saver,
  output logic o_column_drive_outputs_at_supply,
  output logic o_row_drive_outputs_at_supply,
  output logic o_booster_en,
  output logic o_regulator_en,
  output logic o_follower_en,
  output logic o_divider_connect,
  output logic o_reg_feedback,
  output logic o_high_power,
  output logic [3:0] o_bias_denom,
  output logic [5:0] o_contrast,
  output logic [5:0] o_contrast_step,
  output logic [2:0] o_ratio,
  output logic [5:0] o_start_line,
  output logic [7:0] o_column,
  output logic [3:0] o_page,
  output logic o_rmw,
  output logic [1:0] o_static_ind
);

  // =====================================
  // Reset values
  // Full default set
  localparam cfg_t CFG_RST = '{
    display_on: 1'b0,
    inverse: 1'b0,
    seg_reverse: 1'b0,
    power_ctrl: `LCD_POWER_RST,
    bias_alt: 1'b0,
    all_on: 1'b0,
    power_saver: 1'b0,
    drivers_at_supply: 1'b1,
    rmw: 1'b0,
    static_ind: `LCD_STATIC_RST,
    start_line: 6'h00,
    column: 8'h00,
    rmw_column: 8'h00,
    page: 4'h0,
    com_reverse: 1'b0,
    ratio: `LCD_RATIO_RST,
    contrast: `LCD_CONTRAST_RST,
    pend: PEND_NONE
  };

  // Held while the pin is low
  logic hold_reset;
  assign hold_reset = i_reset || !i_init_pin_n;

  // =====================================
  // Serial receiver
  ser_byte_t ser_byte;
  logic ser_valid;
  logic ser_ack;

  lcd_serial_rx u_serial_rx (
    .i_ref_clk(i_ref_clk),
    .i_clk_en(i_clk_en),
    .i_clear(hold_reset),
    .i_ser_cs_n(i_ser_cs_n),
    .i_ser_clk(i_ser_clk),
    .i_ser_data(i_ser_data),
    .i_ser_a0(i_ser_a0),
    .i_ack(ser_ack),
    .o_byte(ser_byte),
    .o_valid(ser_valid)
  );

  // =====================================
  // Command decode
  cfg_t cfg, next_cfg;
  logic bus_cmd, bus_data;
  logic go, is_data;
  logic [7:0] cmd;

  assign bus_cmd = i_wr_en && (i_addr == `LCD_OFS_CMD);
  assign bus_data = i_wr_en && (i_addr == `LCD_OFS_DATA);

  always_comb begin
    next_cfg = cfg;
    go = 1'b0;
    is_data = 1'b0;
    cmd = 8'h00;
    ser_ack = 1'b0;
    // Bus writes first, a serial byte waits a cycle
    if (bus_cmd || bus_data) begin
      go = 1'b1;
      is_data = bus_data;
      cmd = i_wr_data;
    end else if (ser_valid) begin
      go = 1'b1;
      is_data = ser_byte.is_data;
      cmd = ser_byte.data;
      ser_ack = 1'b1;
    end
    if (go && is_data) begin
      if (cfg.column < `LCD_COL_MAX) begin
        next_cfg.column = cfg.column + 8'h01;
      end
    end else if (go) begin
      case (cfg.pend)
        PEND_CONTRAST: begin
          next_cfg.contrast = cmd[5:0];
          next_cfg.pend = PEND_NONE;
        end
        PEND_RATIO: begin
          next_cfg.ratio = cmd[2:0];
          next_cfg.pend = PEND_NONE;
        end
        PEND_STATIC: begin
          next_cfg.static_ind = cmd[1:0];
          next_cfg.pend = PEND_NONE;
        end
        default: begin
          casez (cmd)
            `LCD_CMD_DISPLAY: begin
              next_cfg.display_on = cmd[0];
              if (cmd[0]) begin
                next_cfg.drivers_at_supply = 1'b0;
              end
            end
            `LCD_CMD_START_LINE: next_cfg.start_line = cmd[5:0];
            `LCD_CMD_PAGE: begin
              if (cmd[3:0] <= `LCD_PAGE_MAX) begin
                next_cfg.page = cmd[3:0];
              end
            end
            `LCD_CMD_COL_HIGH: next_cfg.column[7:4] = cmd[3:0];
            `LCD_CMD_COL_LOW: next_cfg.column[3:0] = cmd[3:0];
            `LCD_CMD_SEG_DIR: next_cfg.seg_reverse = cmd[0];
            `LCD_CMD_INVERSE: next_cfg.inverse = cmd[0];
            `LCD_CMD_ALL_ON: next_cfg.all_on = cmd[0];
            `LCD_CMD_BIAS: next_cfg.bias_alt = cmd[0];
            `LCD_CMD_POWER: next_cfg.power_ctrl = cmd[2:0];
            `LCD_CMD_COM_DIR: next_cfg.com_reverse = cmd[`LCD_COM_DIR_BIT];
            `LCD_CMD_STATIC: begin
              if (cmd[0]) begin
                next_cfg.pend = PEND_STATIC;
              end else begin
                next_cfg.static_ind = `LCD_STATIC_RST;
              end
            end
            `LCD_CMD_CONTRAST: next_cfg.pend = PEND_CONTRAST;
            `LCD_CMD_RATIO: next_cfg.pend = PEND_RATIO;
            `LCD_CMD_RMW_ENTER: begin
              next_cfg.rmw = 1'b1;
              next_cfg.rmw_column = cfg.column;
            end
            `LCD_CMD_RMW_EXIT: begin
              next_cfg.rmw = 1'b0;
              if (cfg.rmw) begin
                next_cfg.column = cfg.rmw_column;
              end
            end
            `LCD_CMD_SOFT_RESET: begin
              next_cfg.rmw = CFG_RST.rmw;
              next_cfg.static_ind = CFG_RST.static_ind;
              next_cfg.start_line = CFG_RST.start_line;
              next_cfg.column = CFG_RST.column;
              next_cfg.page = CFG_RST.page;
              next_cfg.com_reverse = CFG_RST.com_reverse;
              next_cfg.contrast = CFG_RST.contrast;
              next_cfg.pend = CFG_RST.pend;
            end
            default: next_cfg = cfg;
          endcase
        end
      endcase
    end
    next_cfg.power_saver = !next_cfg.display_on && next_cfg.all_on;
  end

  always_ff @(posedge i_ref_clk) begin
    if (hold_reset) begin
      cfg <= CFG_RST;
    end else if (i_clk_en) begin
      cfg <= next_cfg;
    end
  end

  // =====================================
  // Supply and drive control
  drive_t drv, next_drv;

  always_comb begin
    next_drv = '0;
    // Individual stage enables, off in saver
    next_drv.booster = cfg.power_ctrl[`LCD_PWR_BOOST_BIT] && !cfg.power_saver;
    next_drv.regulator = cfg.power_ctrl[`LCD_PWR_REG_BIT] && !cfg.power_saver;
    next_drv.follower = cfg.power_ctrl[`LCD_PWR_FOLLOW_BIT] && !cfg.power_saver;
    next_drv.divider_connect = next_drv.regulator && i_regulator_resistor_select;
    next_drv.reg_feedback = i_regulator_resistor_select ? i_internal_feedback : i_feedback_input;
    next_drv.high_power = !i_drive_strength_select;
    next_drv.contrast_step = ~cfg.contrast;
    case (i_duty_sel)
      `LCD_DUTY_65: next_drv.bias_denom = cfg.bias_alt ? `LCD_BIAS_7 : `LCD_BIAS_9;
      `LCD_DUTY_49,
      `LCD_DUTY_53,
      `LCD_DUTY_55: next_drv.bias_denom = cfg.bias_alt ? `LCD_BIAS_6 : `LCD_BIAS_8;
      `LCD_DUTY_33: next_drv.bias_denom = cfg.bias_alt ? `LCD_BIAS_5 : `LCD_BIAS_6;
      default: next_drv.bias_denom = cfg.bias_alt ? `LCD_BIAS_7 : `LCD_BIAS_9;
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (hold_reset) begin
      drv <= '0;
    end else if (i_clk_en) begin
      drv <= next_drv;
    end
  end

  // =====================================
  // Register read port
  logic [7:0] rd_data, next_rd_data;

  always_comb begin
    next_rd_data = 8'h00;
    if (i_rd_en) begin
      case (i_addr)
        `LCD_OFS_STATUS: next_rd_data = {cfg.rmw, cfg.power_saver, cfg.all_on, cfg.display_on,
                                         cfg.inverse, cfg.seg_reverse, cfg.com_reverse,
                                         cfg.drivers_at_supply};
        `LCD_OFS_POWER: next_rd_data = {1'b0, cfg.ratio, 1'b0, cfg.power_ctrl};
        `LCD_OFS_CONTRAST: next_rd_data = {2'h0, cfg.contrast};
        `LCD_OFS_PAGE: next_rd_data = {4'h0, cfg.page};
        `LCD_OFS_COLUMN: next_rd_data = cfg.column;
        `LCD_OFS_START: next_rd_data = {2'h0, cfg.start_line};
        `LCD_OFS_STATIC: next_rd_data = {cfg.pend, 4'h0, cfg.static_ind};
        default: next_rd_data = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (hold_reset) begin
      rd_data <= 8'h00;
    end else if (i_clk_en) begin
      rd_data <= next_rd_data;
    end
  end

  // =====================================
  // Outputs
  assign o_rd_data = rd_data;
  assign o_display_on = cfg.display_on;
  assign o_inverse = cfg.inverse;
  assign o_seg_reverse = cfg.seg_reverse;
  assign o_com_reverse = cfg.com_reverse;
  assign o_all_on = cfg.all_on;
  assign o_power_saver = cfg.power_saver;
  assign o_column_drive_outputs_at_supply = cfg.drivers_at_supply;
  assign o_row_drive_outputs_at_supply = cfg.drivers_at_supply;
  assign o_booster_en = drv.booster;
  assign o_regulator_en = drv.regulator;
  assign o_follower_en = drv.follower;
  assign o_divider_connect = drv.divider_connect;
  assign o_reg_feedback = drv.reg_feedback;
  assign o_high_power = drv.high_power;
  assign o_bias_denom = drv.bias_denom;
  assign o_contrast = cfg.contrast;
  assign o_contrast_step = drv.contrast_step;
  assign o_ratio = cfg.ratio;
  assign o_start_line = cfg.start_line;
  assign o_column = cfg.column;
  assign o_page = cfg.page;
  assign o_rmw = cfg.rmw;
  assign o_static_ind = cfg.static_ind;

endmodule

`default_nettype wire

/* File: sim/lcd_ctrl_reset_power_setup_props.sv */
`timescale 1ns/1ps
`default_nettype none
module lcd_ctrl_reset_power_setup_props
  import lcd_ctrl_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic i_clk_en,
  input wire logic i_init_pin_n,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wr_data,
  input wire logic i_wr_en,
  input wire logic i_regulator_resistor_select,
  input wire logic i_drive_strength_select,
  input wire logic i_feedback_input,
  input wire logic i_internal_feedback,
  input wire logic o_display_on,
  input wire logic o_inverse,
  input wire logic o_all_on,
  input wire logic o_power_saver,
  input wire logic o_column_drive_outputs_at_supply,
  input wire logic o_row_drive_outputs_at_supply,
  input wire logic o_booster_en,
  input wire logic o_regulator_en,
  input wire logic o_follower_en,
  input wire logic o_divider_connect,
  input wire logic o_reg_feedback,
  input wire logic o_high_power,
  input wire logic [5:0] o_contrast,
  input wire logic [5:0] o_contrast_step,
  input wire logic [7:0] o_column
);
  default clocking @(posedge i_ref_clk);
  endclocking
  default disable iff (i_reset);

  // =====
  // Sequences
  sequence s_cmd(d);
    i_wr_en && i_clk_en && i_init_pin_n && i_addr == 4'h0 && i_wr_data == d;
  endsequence
  sequence s_live;
    $past(i_clk_en) && $past(i_init_pin_n) && !$past(i_reset);
  endsequence

  // =====
  // Assertions
  chk_init_display:
    assert property (!i_init_pin_n |=> !o_display_on && !o_inverse && !o_all_on && !o_power_saver)
    else $error("Init pin left display state set");
  chk_init_drivers:
    assert property (!i_init_pin_n |=> o_column_drive_outputs_at_supply && o_row_drive_outputs_at_supply)
    else $error("Drivers not at supply during init");
  chk_init_addr:
    assert property (!i_init_pin_n |=> o_column == 8'h00 && o_contrast == 6'h20)
    else $error("Column or contrast not at default");
  chk_init_power:
    assert property (!i_init_pin_n ##1 !i_init_pin_n |=> !o_booster_en && !o_regulator_en && !o_follower_en
      && !o_divider_connect)
    else $error("Supply stages enabled during init");
  chk_display_cmd:
    assert property (s_cmd(8'haf) |=> o_display_on && !o_column_drive_outputs_at_supply)
    else $error("Display on command not applied");
  chk_saver_entry:
    assert property (s_cmd(8'hae) ##2 s_cmd(8'ha5) |=> o_power_saver ##1 !o_booster_en && !o_regulator_en
      && !o_follower_en)
    else $error("Power saver not entered");
  chk_saver_level:
    assert property (o_power_saver == (o_all_on && !o_display_on))
    else $error("Power saver level wrong");
  chk_step_centre:
    assert property (s_live |-> o_contrast_step == 6'h3f - $past(o_contrast))
    else $error("Contrast step mismatch");
  chk_power_mode:
    assert property (s_live |-> o_high_power == !$past(i_drive_strength_select))
    else $error("High power mode mismatch");
  chk_feedback_sel:
    assert property (s_live |-> o_reg_feedback == ($past(i_regulator_resistor_select) ?
      $past(i_internal_feedback) : $past(i_feedback_input)))
    else $error("Feedback select mismatch");
endmodule

bind lcd_ctrl_reset_power_setup lcd_ctrl_reset_power_setup_props props_i (.*);
`default_nettype wire

/* File: sim/lcd_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module lcd_host_model (
  input wire logic i_ref_clk,
  output logic o_ser_cs_n = 1'b1,
  output logic o_ser_clk = 1'b0,
  output logic o_ser_data = 1'b0,
  output logic o_ser_a0 = 1'b0
);
  // =====
  // One bit, each clock phase two cycles
  task automatic shift(input logic b, input logic a0);
    @(posedge i_ref_clk);
    o_ser_cs_n <= 1'b0;
    o_ser_clk <= 1'b0;
    o_ser_data <= b;
    o_ser_a0 <= a0;
    repeat (2) @(posedge i_ref_clk);
    o_ser_clk <= 1'b1;
    @(posedge i_ref_clk);
  endtask

  // Partial byte, select kept low
  task automatic send_half(input logic [3:0] n);
    for (int i = 3; i >= 0; i--) begin
      shift(n[i], 1'b0);
    end
  endtask

  task automatic send_byte(input logic [7:0] b, input logic a0);
    for (int i = 7; i >= 0; i--) begin
      shift(b[i], a0);
    end
    @(posedge i_ref_clk);
    o_ser_clk <= 1'b0;
    @(posedge i_ref_clk);
    o_ser_cs_n <= 1'b1;
    o_ser_data <= ~o_ser_data;
    o_ser_a0 <= ~o_ser_a0;
  endtask

  task automatic power_down();
    send_byte(8'hae, 1'b0);
    send_byte(8'ha5, 1'b0);
  endtask
endmodule
`default_nettype wire

/* File: sim/lcd_ctrl_reset_power_setup_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module lcd_ctrl_reset_power_setup_bench;
  import lcd_ctrl_pkg::*;
  logic i_ref_clk = 1'b0, i_reset = 1'b1, i_clk_en = 1'b1, i_init_pin_n = 1'b1;
  logic [3:0] i_addr = 4'h0;
  logic [7:0] i_wr_data = 8'h00;
  logic i_wr_en = 1'b0, i_rd_en = 1'b0;
  logic [2:0] i_duty_sel = 3'h0;
  logic i_regulator_resistor_select = 1'b1, i_drive_strength_select = 1'b1;
  logic i_feedback_input = 1'b0, i_internal_feedback = 1'b0;
  logic i_ser_cs_n, i_ser_clk, i_ser_data, i_ser_a0;
  logic [7:0] o_rd_data, o_column, v;
  logic o_display_on, o_inverse, o_seg_reverse, o_com_reverse, o_all_on, o_power_saver;
  logic o_column_drive_outputs_at_supply, o_row_drive_outputs_at_supply;
  logic o_booster_en, o_regulator_en, o_follower_en, o_divider_connect, o_reg_feedback, o_high_power, o_rmw;
  logic [3:0] o_bias_denom, o_page;
  logic [5:0] o_contrast, o_contrast_step, o_start_line;
  logic [2:0] o_ratio;
  logic [1:0] o_static_ind;
  int miscompares = 0, n_compared = 0, cycles = 0;

  lcd_ctrl_reset_power_setup uut (.*);
  lcd_host_model host (.i_ref_clk(i_ref_clk), .o_ser_cs_n(i_ser_cs_n), .o_ser_clk(i_ser_clk),
    .o_ser_data(i_ser_data), .o_ser_a0(i_ser_a0));

  always #2.5 i_ref_clk = ~i_ref_clk;

  always @(posedge i_ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      results();
    end
  end

  // =====
  // Shared tasks
  task automatic results();
    if (miscompares == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_wr_data <= d;
    i_wr_en <= 1'b1;
    @(posedge i_ref_clk);
    i_wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_rd_en <= 1'b1;
    @(posedge i_ref_clk);
    i_rd_en <= 1'b0;
    #1;
    d = o_rd_data;
  endtask

  function automatic logic [7:0] flags();
    return {o_display_on, o_inverse, o_seg_reverse, o_com_reverse, o_all_on, o_power_saver,
      o_column_drive_outputs_at_supply, o_row_drive_outputs_at_supply};
  endfunction

  function automatic logic [7:0] supply();
    return {4'h0, o_booster_en, o_regulator_en, o_follower_en, o_divider_connect};
  endfunction

  // =====
  // Scenarios
  task automatic t_defaults();
    logic [7:0] exp [0:7];
    exp = '{8'h01, 8'h00, 8'h20, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    tick(2);
    check(flags(), 8'h03);
    check(supply(), 8'h00);
    check({2'h0, o_contrast_step}, 8'h1f);
    check({5'h0, o_rmw, o_static_ind}, 8'h00);
    for (int a = 0; a < 7; a++) begin
      rd(4'(a + 2), v);
      check(v, exp[a]);
    end
    rd(4'hf, v);
    check(v, exp[7]);
  endtask

  task automatic t_bias();
    logic [3:0] exp [0:5];
    exp = '{4'h9, 4'h8, 4'h8, 4'h8, 4'h6, 4'h9};
    for (int d = 0; d < 6; d++) begin
      @(posedge i_ref_clk);
      i_duty_sel <= 3'(d);
      tick(3);
      check({4'h0, o_bias_denom}, {4'h0, exp[d]});
    end
  endtask

  task automatic t_modes();
    wr(4'h0, 8'ha3);
    wr(4'h0, 8'h18);
    wr(4'h0, 8'h02);
    wr(4'h0, 8'he0);
    wr(4'h1, 8'h00);
    wr(4'h1, 8'h00);
    tick(2);
    check(o_column, 8'h83);
    check({o_bias_denom, 3'h0, o_rmw}, 8'h71);
    wr(4'h0, 8'hee);
    wr(4'h0, 8'ha2);
    tick(2);
    check(o_column, 8'h82);
    check({o_bias_denom, 3'h0, o_rmw}, 8'h90);
  endtask

  task automatic t_feedback();
    for (int k = 0; k < 8; k++) begin
      @(posedge i_ref_clk);
      {i_regulator_resistor_select, i_feedback_input, i_internal_feedback} <= 3'(k);
      i_drive_strength_select <= k[1];
      tick(2);
      check({6'h0, o_reg_feedback, o_high_power}, {6'h0, k[2] ? k[0] : k[1], ~k[1]});
    end
  endtask

  task automatic t_power_bits();
    for (int k = 0; k < 8; k++) begin
      wr(4'h0, 8'h28 | 8'(k));
      tick(2);
      check(supply(), {4'h0, 3'(k), k[1]});
      rd(4'h3, v);
      check(v, {5'h0, 3'(k)});
    end
  endtask

  task automatic t_soft_reset();
    wr(4'h0, 8'haf);
    wr(4'h0, 8'h2b);
    wr(4'h0, 8'h81);
    wr(4'h0, 8'h3f);
    wr(4'h0, 8'h82);
    wr(4'h0, 8'h05);
    wr(4'h0, 8'hb7);
    tick(2);
    check({o_contrast, o_contrast_step[1:0]}, 8'hfc);
    @(posedge i_ref_clk);
    i_clk_en <= 1'b0;
    wr(4'h0, 8'hae);
    @(posedge i_ref_clk);
    i_clk_en <= 1'b1;
    wr(4'h2, 8'hae);
    wr(4'h0, 8'h45);
    wr(4'h0, 8'h13);
    wr(4'h0, 8'he2);
    tick(2);
    check(flags(), 8'h80);
    check(supply(), 8'h07);
    check({o_contrast, o_start_line[1:0]}, 8'h80);
    check(o_column, 8'h00);
    check({o_ratio, o_page, 1'b0}, 8'ha0);
    wr(4'h0, 8'hae);
    wr(4'h0, 8'ha5);
    tick(3);
    check(flags(), 8'h0c);
    check(supply(), 8'h00);
  endtask

  task automatic t_serial();
    logic [7:0] seq [0:9];
    seq = '{8'ha1, 8'hc8, 8'hb3, 8'h7f, 8'he0, 8'h81, 8'h15, 8'had, 8'h02, 8'h82};
    wr(4'h0, 8'haf);
    wr(4'h0, 8'ha4);
    host.power_down();
    tick(6);
    check(flags(), 8'h0c);
    // Non-default state, ratio byte left pending
    for (int i = 0; i < 10; i++) begin
      wr(4'h0, seq[i]);
    end
    tick(1);
    check({o_seg_reverse, o_com_reverse, o_rmw, o_static_ind, o_page[2:0]}, 8'hf3);
    check({o_contrast, o_ratio[1:0]}, 8'h55);
    check({2'h0, o_start_line}, 8'h3f);
    host.send_half(4'ha);
    @(posedge i_ref_clk);
    i_init_pin_n <= 1'b0;
    tick(3);
    check(flags(), 8'h03);
    check(supply(), 8'h00);
    check({o_seg_reverse, o_com_reverse, o_rmw, o_static_ind, o_page[2:0]}, 8'h00);
    check({o_contrast, o_ratio[1:0]}, 8'h80);
    check({2'h0, o_start_line}, 8'h00);
    @(posedge i_ref_clk);
    i_init_pin_n <= 1'b1;
    host.send_byte(8'ha7, 1'b0);
    tick(6);
    check(flags(), 8'h43);
    rd(4'h8, v);
    check(v, 8'h00);
  endtask

  initial begin
    repeat (10) @(posedge i_ref_clk);
    i_reset <= 1'b0;
    t_defaults();
    t_bias();
    t_modes();
    t_feedback();
    t_power_bits();
    t_soft_reset();
    t_serial();
    results();
  end
endmodule
`default_nettype wire
